// ---- cmds_pkg.sv ----
// Purpose: Constants and types for the CPU module diagnostic setup block.
// Assumes: One system bus clock, synchronous active-low reset.
// Notes: Register reached by a node-space CSR port at its printed offset.
package cmds_pkg;
   localparam logic [15:0] CMDS_DIAG_OFFSET = 16'h1000;
   localparam int CMDS_BIT_SLOW = 15;
   localparam int CMDS_BIT_QWVAL = 14;
   localparam int CMDS_BIT_FLTARM = 13;
   localparam int CMDS_FDE_LO = 8;
   localparam int CMDS_BIT_DBL = 7;
   localparam int CMDS_BIT_TAGCPU = 3;
   localparam int CMDS_BIT_TAGRD = 2;
   localparam int CMDS_BIT_TAGWR = 1;
   localparam int CMDS_BIT_ISO = 0;
   localparam logic [31:0] CMDS_RW_MASK = 32'h0000_EF89;
   localparam int CMDS_DIV_SLOW = 12;
   localparam int CMDS_DIV_FAST = 6;
   localparam int CMDS_ISO_COPIES = 4;
   localparam logic [31:0] CMDS_DIAG_RESET = 32'h0000_0001;
   localparam int CMDS_FDE_W = 4;
   localparam logic [1:0] CMDS_ECC_NONE = 2'h0;
   localparam logic [1:0] CMDS_ECC_SINGLE = 2'h1;
   localparam logic [1:0] CMDS_ECC_DOUBLE = 2'h3;

   typedef struct packed {
      logic valid;
      logic write;
      logic [15:0] addr;
      logic [31:0] wdata;
   } cmds_csr_req_t;

   typedef struct packed {
      logic valid;
      logic memSpace;
      logic [63:0] data;
      logic [7:0] ctrl;
   } cmds_txn_t;

   typedef struct packed {
      logic [19:0] tagData;
      logic [3:0] tagStat;
   } cmds_tag_t;
endpackage

// ---- cmds_diag_setup.sv ----
// Purpose: Diagnostic setup register and the logic it steers on the CPU module.
// Assumes: Tag RAM and bus interface are outside; this block drives their controls.
// Notes: Trigger bits are write-only and read back as zero.
`timescale 1ns/1ns
module cmds_diag_setup
   import cmds_pkg::*;
#(
   parameter int ISO_COPIES = CMDS_ISO_COPIES
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic powerUp,
   // CSR port.
   input wire cmds_csr_req_t csrReq,
   output logic csrAck,
   output logic [31:0] csrRdata,
   // Outgoing transactions from the processors.
   input wire cmds_txn_t txOut,
   output cmds_txn_t busTx,
   output cmds_txn_t loopRx,
   // Incoming bus transactions and arbitration.
   input wire cmds_txn_t busRx,
   input wire logic arbReq,
   output cmds_txn_t rxToCore,
   output logic arbReqBus,
   // Controls and status.
   output logic slowPeripheralClock,
   output logic quadwordValidEnable,
   output logic systemBusFault,
   output logic [3:0] forceEccMask,
   output logic [1:0] eccFlip,
   output logic [ISO_COPIES-1:0] isolateCopy,
   // Duplicate-tag diagnostic port.
   input wire logic memReadDone,
   input wire cmds_tag_t tagReadData,
   output logic tagWriteEn,
   output logic tagCpuSel,
   output cmds_tag_t tagWriteData,
   output cmds_tag_t tagRegs
);
   // Settings the logic cannot serve are refused at elaboration.
   localparam int DIV_CNT_W = 4;
   localparam int DIV_CNT_MAX = (1 << DIV_CNT_W) - 1;
   if (ISO_COPIES < 1) begin : gBadCopies
      $error("ISO_COPIES must be at least 1");
   end
   if (CMDS_DIV_FAST < 2 || CMDS_DIV_SLOW / 2 > DIV_CNT_MAX) begin : gBadDivisor
      $error("Peripheral clock divisors do not fit the divider counter");
   end
   if (CMDS_DIV_FAST % 2 != 0 || CMDS_DIV_SLOW % 2 != 0) begin : gOddDivisor
      $error("Peripheral clock divisors must be even");
   end

   ////////////////////////////////////////////////////////////////////////////////
   logic [31:0] diag_q;
   logic tagRd_q;
   logic tagWr_q;
   logic csrHit;
   logic wrHit;
   logic rdHit;
   logic fltPend_q;
   // Only the one register offset is decoded; other offsets get no acknowledge.
   assign csrHit = csrReq.valid && (csrReq.addr == CMDS_DIAG_OFFSET);
   assign wrHit = csrHit && csrReq.write;
   assign rdHit = csrHit && !csrReq.write;

   // A single shared register; reserved bits stay zero.
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         diag_q <= CMDS_DIAG_RESET;
      end else if (wrHit) begin
         diag_q <= csrReq.wdata & CMDS_RW_MASK;
      end
      if (!rstn && powerUp) begin
         diag_q[CMDS_BIT_FLTARM] <= 1'b0;
      end
   end

   // Tag triggers, valid only while isolated, cleared when the read finishes.
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         tagRd_q <= 1'b0;
         tagWr_q <= 1'b0;
      end else if (wrHit) begin
         tagRd_q <= csrReq.wdata[CMDS_BIT_TAGRD] & csrReq.wdata[CMDS_BIT_ISO];
         tagWr_q <= csrReq.wdata[CMDS_BIT_TAGWR] & csrReq.wdata[CMDS_BIT_ISO];
      end else if (memReadDone || !diag_q[CMDS_BIT_ISO]) begin
         tagRd_q <= 1'b0;
         tagWr_q <= 1'b0;
      end
   end

   // Tag registers load on a diagnostic read; parity passes unchanged.
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         tagRegs <= '0;
         tagWriteEn <= 1'b0;
         tagWriteData <= '0;
      end else begin
         if (tagRd_q && memReadDone) begin
            tagRegs <= tagReadData;
         end
         tagWriteEn <= tagWr_q && memReadDone;
         tagWriteData <= tagRegs;
      end
   end

   // Fault asserts when isolation falls with the arm bit set.
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         fltPend_q <= 1'b0;
      end else if (wrHit && diag_q[CMDS_BIT_ISO] && !csrReq.wdata[CMDS_BIT_ISO]
                   && diag_q[CMDS_BIT_FLTARM]) begin
         fltPend_q <= 1'b1;
      end else if (wrHit && csrReq.wdata[CMDS_BIT_ISO]) begin
         fltPend_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Peripheral clock divider: half a period is counted, then the output toggles.
   // A divisor change acts within the running half period, so one period may be short.
   logic [DIV_CNT_W-1:0] divCnt_q;
   logic [DIV_CNT_W-1:0] divHalf;
   always_comb begin
      if (diag_q[CMDS_BIT_SLOW]) begin
         divHalf = DIV_CNT_W'(CMDS_DIV_SLOW / 2);
      end else begin
         divHalf = DIV_CNT_W'(CMDS_DIV_FAST / 2);
      end
   end
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         divCnt_q <= '0;
         slowPeripheralClock <= 1'b0;
      end else if (divCnt_q >= divHalf - DIV_CNT_W'(1)) begin
         divCnt_q <= '0;
         slowPeripheralClock <= ~slowPeripheralClock;
      end else begin
         divCnt_q <= divCnt_q + DIV_CNT_W'(1);
      end
   end

   // Distributed isolation copies.
   genvar g;
   generate
      for (g = 0; g < ISO_COPIES; g++) begin : gIso
         always_ff @(posedge clk_sys) begin
            if (!rstn) begin
               isolateCopy[g] <= CMDS_DIAG_RESET[CMDS_BIT_ISO];
            end else begin
               isolateCopy[g] <= diag_q[CMDS_BIT_ISO];
            end
         end
      end
   endgenerate

   // Mode bits copied out to the bus interface and the data path.
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         quadwordValidEnable <= 1'b0;
         forceEccMask <= '0;
         tagCpuSel <= 1'b0;
      end else begin
         quadwordValidEnable <= diag_q[CMDS_BIT_QWVAL];
         forceEccMask <= diag_q[CMDS_FDE_LO +: CMDS_FDE_W];
         tagCpuSel <= diag_q[CMDS_BIT_TAGCPU];
      end
   end

   // Error kind for memory-space data while any quadword is forced.
   logic eccForce;
   assign eccForce = |diag_q[CMDS_FDE_LO +: CMDS_FDE_W] && txOut.memSpace;
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         eccFlip <= CMDS_ECC_NONE;
      end else if (!eccForce) begin
         eccFlip <= CMDS_ECC_NONE;
      end else if (diag_q[CMDS_BIT_DBL]) begin
         eccFlip <= CMDS_ECC_DOUBLE;
      end else begin
         eccFlip <= CMDS_ECC_SINGLE;
      end
   end

   // The fault stays driven until isolation is set again, so a faulted module stays visible.
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         systemBusFault <= 1'b0;
      end else begin
         systemBusFault <= fltPend_q;
      end
   end

   // Bus gating and loopback, steered by the first isolation copy.
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         busTx <= '0;
         loopRx <= '0;
         rxToCore <= '0;
         arbReqBus <= 1'b0;
      end else begin
         busTx <= isolateCopy[0] ? '0 : txOut;
         loopRx <= isolateCopy[0] ? txOut : '0;
         rxToCore <= isolateCopy[0] ? '0 : busRx;
         arbReqBus <= arbReq && !isolateCopy[0];
      end
   end

   // CSR read path; isolation reads from its copy.
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         csrAck <= 1'b0;
         csrRdata <= 32'h0000_0000;
      end else begin
         csrAck <= csrHit;
         csrRdata <= 32'h0000_0000;
         if (rdHit) begin
            csrRdata <= {diag_q[31:1], isolateCopy[0]} & CMDS_RW_MASK;
         end
      end
   end
endmodule // cmds_diag_setup

// ---- cmds_diag_setup_assertions.sv ----
// Purpose: Port checks for the diagnostic setup block.
// Assumes: One clock, reset active low.
// Notes: Bound into every instance.
`timescale 1ns/1ns
module cmds_diag_setup_assertions
   import cmds_pkg::*;
#(parameter int ISO_COPIES = 4) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rstn,
   // Watched ports.
   input wire cmds_csr_req_t csrReq,
   input wire logic csrAck,
   input wire cmds_txn_t txOut,
   input wire cmds_txn_t busTx,
   input wire cmds_txn_t loopRx,
   input wire logic arbReqBus,
   input wire logic quadwordValidEnable,
   input wire logic systemBusFault,
   input wire logic [ISO_COPIES-1:0] isolateCopy
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   logic hit, wr, iso;
   assign hit = csrReq.valid && csrReq.addr == CMDS_DIAG_OFFSET;
   assign wr = hit && csrReq.write;
   assign iso = &isolateCopy;
   a_ack_on_hit: assert property (hit |=> csrAck)
      else $error("no ack");
   a_no_stray_ack: assert property (!hit |=> !csrAck)
      else $error("stray ack");
   a_qword_copy: assert property (wr |=> ##1 quadwordValidEnable == $past(csrReq.wdata[14], 2))
      else $error("qword bit");
   a_iso_copy: assert property (wr |=> ##1 isolateCopy == {ISO_COPIES{$past(csrReq.wdata[0], 2)}})
      else $error("iso copies");
   a_arb_drop: assert property (iso && $past(iso) |-> !arbReqBus)
      else $error("arb while isolated");
   a_no_bus_tx: assert property (iso && $past(iso) |-> !busTx.valid)
      else $error("bus tx while isolated");
   a_loop_back: assert property (iso && $past(iso) && $past(rstn) |-> loopRx.valid == $past(txOut.valid))
      else $error("no loopback");
   a_fault_cause: assert property ($rose(systemBusFault) |-> $fell(isolateCopy[0]))
      else $error("fault cause");
   cover property (wr && csrReq.wdata[13]);
   cover property ($rose(systemBusFault));
   cover property (!iso && busTx.valid);
endmodule // cmds_diag_setup_assertions
bind cmds_diag_setup cmds_diag_setup_assertions #(.ISO_COPIES(ISO_COPIES)) u_chk (
   .clk_sys(clk_sys), .rstn(rstn), .csrReq(csrReq), .csrAck(csrAck), .txOut(txOut),
   .busTx(busTx), .loopRx(loopRx), .arbReqBus(arbReqBus),
   .quadwordValidEnable(quadwordValidEnable), .systemBusFault(systemBusFault),
   .isolateCopy(isolateCopy));

// ---- tb_cpu_module_diag_setup.sv ----
// Purpose: Self-checking bench for the diagnostic setup block.
// Assumes: Inputs change on the falling edge.
// Notes: Read data is matched against queued notes.
`timescale 1ns/1ns
module tb_cpu_module_diag_setup
   import cmds_pkg::*;
;
   logic clk_sys = 0, rstn = 0, powerUp = 1, arbReq = 1, mrd = 0;
   cmds_csr_req_t req = '0;
   cmds_txn_t tx = '0, btx, lrx, rcx;
   cmds_tag_t trd = '0, treg, twd;
   logic ack, sc, qv, flt, twe, sel, arb;
   logic [31:0] rd, r, s = 32'h0000_0010;
   logic [3:0] fm;
   logic [1:0] ef;
   logic [63:0] q[$];
   logic [63:0] nt;
   time t;
   int num_errors = 0, num_checks = 0;
   always #50 clk_sys = ~clk_sys;
   cmds_diag_setup dut (.clk_sys(clk_sys), .rstn(rstn), .powerUp(powerUp), .csrReq(req),
      .csrAck(ack), .csrRdata(rd), .txOut(tx), .busTx(btx), .loopRx(lrx), .busRx(tx),
      .arbReq(arbReq), .rxToCore(rcx), .arbReqBus(arb), .slowPeripheralClock(sc),
      .quadwordValidEnable(qv), .systemBusFault(flt), .forceEccMask(fm), .eccFlip(ef),
      .isolateCopy(), .memReadDone(mrd), .tagReadData(trd), .tagWriteEn(twe),
      .tagCpuSel(sel), .tagWriteData(twd), .tagRegs(treg));
   function automatic logic [31:0] rnd();
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic csr(logic w, logic [31:0] d, logic [31:0] m, logic [31:0] e,
                      logic [15:0] a = CMDS_DIAG_OFFSET);
      @(negedge clk_sys);
      req = '{1'b1, w, a, d};
      if (a == CMDS_DIAG_OFFSET) q.push_back({m, e});
      @(negedge clk_sys);
      req.valid = 0;
   endtask
   task automatic wait_rise();
      while (sc !== 1'b0) @(negedge clk_sys);
      while (sc !== 1'b1) @(negedge clk_sys);
   endtask
   task automatic per(int e);
      repeat (2) wait_rise();
      t = $time;
      wait_rise();
      chk("period", 32'(e * 100), 32'($time - t));
   endtask
   task automatic pulse();
      @(negedge clk_sys) mrd = 1;
      @(negedge clk_sys) mrd = 0;
   endtask
   task automatic give_verdict();
      if (num_errors == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   always @(negedge clk_sys) if (ack === 1'b1) begin
      if (q.size() == 0) chk("ack", 0, 1);
      else begin
         nt = q.pop_front();
         chk("csrRdata", nt[31:0], rd & nt[63:32]);
      end
   end
   initial begin
      repeat (10) @(negedge clk_sys);
      rstn = 1;
      powerUp = 0;
      csr(0, 0, '1, 32'h1);
      csr(0, 0, 0, 0, 16'h1040);
      r = rnd() | 32'h1;
      csr(1, r, 0, 0);
      csr(0, 0, '1, r & 32'h0000_EF89);
      chk("qv", r[14], qv);
      chk("fm", r[11:8], fm);
      chk("sel", r[3], sel);
      chk("arb", 0, arb);
      csr(1, 32'h1, 0, 0);
      per(6);
      csr(1, 32'h8001, 0, 0);
      per(12);
      for (int i = 0; i < 2; i++) begin
         csr(1, 32'h0501 | (i << 7), 0, 0);
         tx = '{1'b1, 1'b1, {rnd(), rnd()}, 8'h00};
         repeat (2) @(negedge clk_sys);
         chk("ecc", {i[0], 1'b1}, ef);
         chk("loop", 1, lrx.valid);
         chk("rx", 0, rcx.valid);
         tx.memSpace = 0;
         repeat (2) @(negedge clk_sys);
         chk("ecc", 0, ef);
      end
      csr(1, 32'h2001, 0, 0);
      csr(1, 32'h0, 0, 0);
      repeat (2) @(negedge clk_sys);
      chk("fault", 1, flt);
      chk("btx", 1, btx.valid);
      chk("arb", 1, arb);
      chk("rx", 1, rcx.valid);
      chk("loop", 0, lrx.valid);
      arbReq = 0;
      @(negedge clk_sys);
      chk("arb", 0, arb);
      // Node reset in mid-run with power held good.
      @(negedge clk_sys) rstn = 0;
      repeat (2) @(negedge clk_sys);
      rstn = 1;
      chk("fault", 0, flt);
      csr(0, 0, '1, 32'h1);
      csr(1, 32'hD, 0, 0);
      r = rnd();
      trd = r[23:0];
      pulse();
      chk("treg", r[23:0], treg);
      csr(1, 32'hB, 0, 0);
      pulse();
      chk("twe", 1, twe);
      chk("twd", r[23:0], twd);
      pulse();
      chk("twe", 0, twe);
      give_verdict();
   end
   initial begin
      #1000000;
      num_errors++;
      give_verdict();
   end
endmodule // tb_cpu_module_diag_setup
